// ===== bench/smi_enable_routing_tb_top.sv
`timescale 1ns/1ns
module smi_enable_routing_tb_top;
    logic        mclk = 0, rst = 1, wr = 0, rd = 0, mouse_irq = 0, keyboard_irq = 0, ir_pin = 0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, taken;
    logic [10:0] gp = 11'h000, t;
    logic        pin_n, serial_req, wake_req, group, irq;
    logic        click = 0, group2;
    logic [3:0]  uart = 4'h0;
    logic [7:0]  rdata2;
    logic [31:0] seed = 32'h0338_6f81;
    int          n_mismatch = 0, n_tests = 0, cyc = 0;

    smi_enable_routing smi_enable_routing_i (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .mouse_irq(mouse_irq), .keyboard_irq(keyboard_irq), .mouse_click_event(click),
        .uart_irq(uart), .infrared_receive_pin(ir_pin), .gpio_line_21(gp[0]),
        .gpio_line_22(gp[1]), .gpio_line_54(gp[2]), .gpio_line_55(gp[3]),
        .gpio_line_56(gp[4]), .gpio_line_57(gp[5]), .gpio_line_60(gp[6]),
        .gpio_line_61(gp[7]), .gpio_line_32(gp[8]), .gpio_line_33(gp[9]),
        .gpio_line_42(gp[10]), .mgmt_irq_out_pin_n(pin_n), .serial_irq_request(serial_req),
        .wake_event_request(wake_req), .group_mgmt_irq(group), .irq(irq));
    smi_host_model smi_host_model_i (
        .mclk(mclk), .rst(rst), .mgmt_irq_out_pin_n(pin_n), .taken(taken));
    // Two-port build on the same inputs; its read data and group are watched
    smi_enable_routing #(.SIX_PORT(1'b0)) smi_enable_routing_two_i (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata2),
        .mouse_irq(mouse_irq), .keyboard_irq(keyboard_irq), .mouse_click_event(click),
        .uart_irq(uart), .infrared_receive_pin(ir_pin), .gpio_line_21(gp[0]),
        .gpio_line_22(gp[1]), .gpio_line_54(gp[2]), .gpio_line_55(gp[3]),
        .gpio_line_56(gp[4]), .gpio_line_57(gp[5]), .gpio_line_60(gp[6]),
        .gpio_line_61(gp[7]), .gpio_line_32(gp[8]), .gpio_line_33(gp[9]),
        .gpio_line_42(gp[10]), .mgmt_irq_out_pin_n(), .serial_irq_request(),
        .wake_event_request(), .group_mgmt_irq(group2), .irq());

    always #4 mclk = ~mclk;

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected latches for a set of toggled pins
    function automatic logic [7:0] exp_misc(logic [10:0] m);
        return {2'b00, m[7], m[6], 2'b00, m[1], m[0]};
    endfunction
    function automatic logic [7:0] exp_st4(logic [10:0] m);
        return {m[7], 1'b0, m[10], 1'b0, m[9], m[8], 2'b00};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(logic [7:0] a, logic [7:0] exp, string what);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        cmp(what, exp, rdata);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(smi_routing_pkg::OFF_EN2, 8'h00, "en2 reset");
        rd_chk(smi_routing_pkg::OFF_EN3, 8'h00, "en3 reset");
        rd_chk(smi_routing_pkg::OFF_EN4, 8'h00, "en4 reset");
        rd_chk(smi_routing_pkg::OFF_MISC, 8'h00, "misc reset");
        rd_chk(8'h3f, 8'h00, "unmapped");
        $display("test reset done");
        // Random enables read back through their masks
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            wr_reg(smi_routing_pkg::OFF_EN2, seed[7:0]);
            wr_reg(smi_routing_pkg::OFF_EN3, seed[15:8]);
            wr_reg(smi_routing_pkg::OFF_EN4, seed[23:16]);
            rd_chk(smi_routing_pkg::OFF_EN2, seed[7:0] & 8'hf7, "en2");
            rd_chk(smi_routing_pkg::OFF_EN3, seed[15:8] & 8'hfe, "en3");
            rd_chk(smi_routing_pkg::OFF_EN4, seed[23:16], "en4");
            cmp("en4 two-port", seed[23:16] & 8'hac, rdata2);
        end
        wr_reg(smi_routing_pkg::OFF_EN2, 8'h00);
        wr_reg(smi_routing_pkg::OFF_EN3, 8'h00);
        wr_reg(smi_routing_pkg::OFF_EN4, 8'h00);
        $display("test enables done");
        // Random pin toggles with all sources blocked
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            t = seed[10:0];
            @(posedge mclk);
            gp <= gp ^ t;
            settle(6);
            cmp("group blocked", 8'h00, {7'b0, group});
            rd_chk(smi_routing_pkg::OFF_MISC, exp_misc(t), "misc");
            rd_chk(smi_routing_pkg::OFF_STATUS3, {t[6:0], 1'b0}, "status3");
            rd_chk(smi_routing_pkg::OFF_STATUS4, exp_st4(t), "status4");
            wr_reg(smi_routing_pkg::OFF_MISC, 8'h00);
            rd_chk(smi_routing_pkg::OFF_MISC, exp_misc(t), "misc zero write");
            wr_reg(smi_routing_pkg::OFF_MISC, 8'hff);
            wr_reg(smi_routing_pkg::OFF_STATUS3, 8'hff);
            wr_reg(smi_routing_pkg::OFF_STATUS4, 8'hff);
            rd_chk(smi_routing_pkg::OFF_MISC, 8'h00, "misc cleared");
            rd_chk(smi_routing_pkg::OFF_STATUS3, 8'h00, "status3 cleared");
        end
        $display("test edges done");
        // One enabled pin routed to all three outputs
        wr_reg(smi_routing_pkg::OFF_EN3, 8'h02);
        wr_reg(smi_routing_pkg::OFF_EN2, 8'he0);
        wr_reg(smi_routing_pkg::OFF_EVT_ENABLE, 8'h01);
        @(posedge mclk);
        gp[0] <= ~gp[0];
        settle(6);
        cmp("group", 8'h01, {7'b0, group});
        cmp("pin", 8'h00, {7'b0, pin_n});
        cmp("serial", 8'h01, {7'b0, serial_req});
        cmp("wake", 8'h01, {7'b0, wake_req});
        cmp("irq", 8'h01, {7'b0, irq});
        cmp("host taken", 8'h01, taken);
        wr_reg(smi_routing_pkg::OFF_EVT_ENABLE, 8'h00);
        settle(2);
        cmp("irq masked", 8'h00, {7'b0, irq});
        wr_reg(smi_routing_pkg::OFF_EN2, 8'h00);
        settle(3);
        cmp("routes off", 8'h05, {5'b0, pin_n, serial_req | wake_req, group});
        wr_reg(smi_routing_pkg::OFF_STATUS3, 8'h02);
        settle(3);
        cmp("group cleared", 8'h00, {7'b0, group});
        wr_reg(smi_routing_pkg::OFF_EVT_ENABLE, 8'h01);
        settle(2);
        cmp("irq pending", 8'h01, {7'b0, irq});
        wr_reg(smi_routing_pkg::OFF_EVT_CLEAR, 8'h01);
        settle(3);
        cmp("irq cleared", 8'h00, {7'b0, irq});
        wr_reg(smi_routing_pkg::OFF_MISC, 8'hff);
        $display("test routing done");
        // Level sources and the read-cleared infrared event
        wr_reg(smi_routing_pkg::OFF_EN2, 8'h87);
        @(posedge mclk);
        mouse_irq <= 1'b1;
        settle(4);
        cmp("mouse group", 8'h01, {7'b0, group});
        @(posedge mclk);
        mouse_irq <= 1'b0;
        keyboard_irq <= 1'b1;
        settle(4);
        cmp("keyboard group", 8'h01, {7'b0, group});
        @(posedge mclk);
        keyboard_irq <= 1'b0;
        settle(4);
        cmp("group idle", 8'h00, {7'b0, group});
        @(posedge mclk);
        ir_pin <= 1'b1;
        settle(6);
        cmp("ir group", 8'h01, {7'b0, group});
        rd_chk(smi_routing_pkg::OFF_STATUS2, 8'h04, "status2 ir");
        rd_chk(smi_routing_pkg::OFF_STATUS2, 8'h00, "status2 read clear");
        $display("test sources done");
        // Click event and UART sources; the two-port build must ignore UARTs
        wr_reg(smi_routing_pkg::OFF_EN2, 8'h10);
        wr_reg(smi_routing_pkg::OFF_EN4, 8'h01);
        @(posedge mclk);
        click <= 1'b1;
        @(posedge mclk);
        click <= 1'b0;
        settle(3);
        cmp("click group", 8'h01, {7'b0, group});
        rd_chk(smi_routing_pkg::OFF_STATUS2, 8'h10, "status2 click");
        wr_reg(smi_routing_pkg::OFF_STATUS2, 8'h10);
        settle(2);
        cmp("click cleared", 8'h00, {7'b0, group});
        @(posedge mclk);
        uart <= 4'h1;
        @(posedge mclk);
        uart <= 4'h0;
        settle(3);
        cmp("uart group", 8'h01, {7'b0, group});
        cmp("uart two-port group", 8'h00, {7'b0, group2});
        rd_chk(smi_routing_pkg::OFF_STATUS4, 8'h01, "status4 uart");
        cmp("status4 two-port", 8'h00, rdata2);
        wr_reg(smi_routing_pkg::OFF_STATUS4, 8'hff);
        rd_chk(smi_routing_pkg::OFF_STATUS4, 8'h00, "status4 cleared");
        $display("test click and uart done");
        close_out();
    end
endmodule

// ===== bench/smi_host_model.sv
`timescale 1ns/1ns
// Chipset side: counts management interrupts taken from the active low pin
module smi_host_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       mgmt_irq_out_pin_n,
    output logic      [7:0] taken
);
    logic pin_q;
    // Falling edge only, so a held level counts once
    always_ff @(posedge mclk) begin
        pin_q <= mgmt_irq_out_pin_n;
        if (rst) begin
            taken <= 8'h00;
        end else if (pin_q && !mgmt_irq_out_pin_n) begin
            taken <= taken + 8'h01;
        end
    end
endmodule

// ===== bench/smi_routing_props.sv
`timescale 1ns/1ns
module smi_routing_props (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       mgmt_irq_out_pin_n,
    input wire logic       serial_irq_request,
    input wire logic       wake_event_request,
    input wire logic       group_mgmt_irq,
    input wire logic       irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Routed outputs only ever carry the group level
    property p_pin_group; !mgmt_irq_out_pin_n |-> group_mgmt_irq; endproperty
    a_pin_group: assert property (p_pin_group) else $error("pin low without group");
    property p_serial_group; serial_irq_request |-> group_mgmt_irq; endproperty
    a_serial_group: assert property (p_serial_group) else $error("serial without group");
    property p_wake_group; wake_event_request |-> group_mgmt_irq; endproperty
    a_wake_group: assert property (p_wake_group) else $error("wake without group");

    // Clearing a route bit releases that route two edges later
    property p_pin_off;
        (wr && addr == smi_routing_pkg::OFF_EN2 && !wdata[7]) |-> ##2 mgmt_irq_out_pin_n;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin still driven");
    property p_serial_off;
        (wr && addr == smi_routing_pkg::OFF_EN2 && !wdata[6]) |-> ##2 !serial_irq_request;
    endproperty
    a_serial_off: assert property (p_serial_off) else $error("serial still routed");
    property p_wake_off;
        (wr && addr == smi_routing_pkg::OFF_EN2 && !wdata[5]) |-> ##2 !wake_event_request;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("wake still routed");

    // Reserved misc bits never read back set
    property p_misc_zero;
        (rd && addr == smi_routing_pkg::OFF_MISC) |=> (rdata & 8'hcc) == 8'h00;
    endproperty
    a_misc_zero: assert property (p_misc_zero) else $error("misc reserved bits set");
    property p_reset_out;
        $fell(rst) |-> !group_mgmt_irq && mgmt_irq_out_pin_n && !irq && rdata == 8'h00;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle at reset");
endmodule
bind smi_enable_routing smi_routing_props smi_routing_props_i (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .mgmt_irq_out_pin_n(mgmt_irq_out_pin_n), .serial_irq_request(serial_irq_request),
    .wake_event_request(wake_event_request), .group_mgmt_irq(group_mgmt_irq), .irq(irq));

// ===== hw/smi_enable_routing.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns

module smi_enable_routing #(
    parameter bit SIX_PORT = 1'b1
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       mouse_irq,
    input  wire logic       keyboard_irq,
    input  wire logic       mouse_click_event,
    input  wire logic [3:0] uart_irq,
    input  wire logic       infrared_receive_pin,
    input  wire logic       gpio_line_21,
    input  wire logic       gpio_line_22,
    input  wire logic       gpio_line_54,
    input  wire logic       gpio_line_55,
    input  wire logic       gpio_line_56,
    input  wire logic       gpio_line_57,
    input  wire logic       gpio_line_60,
    input  wire logic       gpio_line_61,
    input  wire logic       gpio_line_32,
    input  wire logic       gpio_line_33,
    input  wire logic       gpio_line_42,
    output logic            mgmt_irq_out_pin_n,
    output logic            serial_irq_request,
    output logic            wake_event_request,
    output logic            group_mgmt_irq,
    output logic            irq
);

    localparam int NP = smi_routing_pkg::NUM_PINS;

    logic [NP-1:0] pins;
    logic [NP-1:0] pin_meta;
    logic [NP-1:0] pin_sync;
    logic [NP-1:0] pin_prev;
    logic [NP-1:0] pin_edge;

    logic [7:0] en2;
    logic [7:0] en3;
    logic [7:0] en4;
    logic [7:0] status2;
    logic       mouse_level;
    logic       keyboard_level;
    logic       infrared_seen;
    logic       click_seen;
    logic       wr_status2;
    logic       rd_status2;
    logic [7:0] status3;
    logic [7:0] status4;
    logic [7:0] misc_status;
    logic [7:0] evt_status;
    logic [7:0] evt_enable;

    logic [7:0] set3;
    logic [7:0] set4;
    logic [7:0] set_misc;
    logic [7:0] en4_mask;
    logic [3:0] uart_live;
    logic       wr_status3;
    logic       wr_status4;
    logic       wr_misc;
    logic       wr_evt_clear;
    logic       next_group;
    logic [7:0] evt_set;
    logic [7:0] next_rdata;

    // Pin vector, ordered by the package indices
    assign pins = {infrared_receive_pin, gpio_line_42, gpio_line_33, gpio_line_32,
                   gpio_line_61, gpio_line_60, gpio_line_57, gpio_line_56,
                   gpio_line_55, gpio_line_54, gpio_line_22, gpio_line_21};

    // Two-flop synchroniser; only the second stage feeds the edge detect
    // Cleared in reset, like idle pins, so release brings no false edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_prev <= '0;
        end else begin
            pin_meta <= pins;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Either edge on any synchronised pin
    // One-cycle pulse per transition; pin pulses under a clock may be lost
    assign pin_edge = pin_sync ^ pin_prev;

    // Reserved UART positions vanish in the two-port build
    assign en4_mask  = SIX_PORT ? smi_routing_pkg::EN4_SIX_MASK
                                : smi_routing_pkg::EN4_TWO_MASK;
    assign uart_live = SIX_PORT ? uart_irq : 4'h0;

    // Strobe decodes for the self-clearing status bits
    // Decoded once, so every clear sees the same address compare
    assign wr_status2   = wr && (addr == smi_routing_pkg::OFF_STATUS2);
    assign rd_status2   = rd && (addr == smi_routing_pkg::OFF_STATUS2);
    assign wr_status3   = wr && (addr == smi_routing_pkg::OFF_STATUS3);
    assign wr_status4   = wr && (addr == smi_routing_pkg::OFF_STATUS4);
    assign wr_misc      = wr && (addr == smi_routing_pkg::OFF_MISC);
    assign wr_evt_clear = wr && (addr == smi_routing_pkg::OFF_EVT_CLEAR);

    // Event sources of the third status register, bit 0 unused
    assign set3 = {pin_edge[smi_routing_pkg::PIN_GPIO_LINE_60],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_57],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_56],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_55],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_54],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_22],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_21],
                   1'b0};

    // Event sources of the fourth status register
    assign set4 = {pin_edge[smi_routing_pkg::PIN_GPIO_LINE_61],
                   uart_live[3],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_42],
                   uart_live[2],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_33],
                   pin_edge[smi_routing_pkg::PIN_GPIO_LINE_32],
                   uart_live[1],
                   uart_live[0]};

    // Either-edge sources of the miscellaneous status register
    assign set_misc = {2'b00,
                       pin_edge[smi_routing_pkg::PIN_GPIO_LINE_61],
                       pin_edge[smi_routing_pkg::PIN_GPIO_LINE_60],
                       2'b00,
                       pin_edge[smi_routing_pkg::PIN_GPIO_LINE_22],
                       pin_edge[smi_routing_pkg::PIN_GPIO_LINE_21]};

    // Sticky status bits; a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sticky
            always_ff @(posedge mclk) begin
                if (rst) begin
                    status3[gi] <= smi_routing_pkg::REG_RESET[gi];
                end else if (set3[gi]) begin
                    status3[gi] <= 1'b1;
                end else if (wr_status3 && wdata[gi]) begin
                    status3[gi] <= 1'b0;
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    status4[gi] <= smi_routing_pkg::REG_RESET[gi];
                end else if (set4[gi] && en4_mask[gi]) begin
                    status4[gi] <= 1'b1;
                end else if (wr_status4 && wdata[gi]) begin
                    status4[gi] <= 1'b0;
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    misc_status[gi] <= smi_routing_pkg::REG_RESET[gi];
                end else if (set_misc[gi] && smi_routing_pkg::MISC_MASK[gi]) begin
                    misc_status[gi] <= 1'b1;
                end else if (wr_misc && wdata[gi]) begin
                    misc_status[gi] <= 1'b0;
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    evt_status[gi] <= smi_routing_pkg::REG_RESET[gi];
                end else if (evt_set[gi] && smi_routing_pkg::EVT_MASK[gi]) begin
                    evt_status[gi] <= 1'b1;
                end else if (wr_evt_clear && wdata[gi]) begin
                    evt_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mouse and keyboard levels; cleared at their source, so never sticky
    always_ff @(posedge mclk) begin
        if (rst) begin
            mouse_level    <= 1'b0;
            keyboard_level <= 1'b0;
        end else begin
            mouse_level    <= mouse_irq;
            keyboard_level <= keyboard_irq;
        end
    end

    // Infrared status: any transition of the infrared pin sets, a read clears
    // A transition in the reading cycle wins, so no event is lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            infrared_seen <= 1'b0;
        end else if (pin_edge[smi_routing_pkg::PIN_IR]) begin
            infrared_seen <= 1'b1;
        end else if (rd_status2) begin
            infrared_seen <= 1'b0;
        end
    end

    // Specific mouse click: sticky, cleared by writing one
    always_ff @(posedge mclk) begin
        if (rst) begin
            click_seen <= 1'b0;
        end else if (mouse_click_event) begin
            click_seen <= 1'b1;
        end else if (wr_status2 && wdata[smi_routing_pkg::BIT_MOUSE_CLICK]) begin
            click_seen <= 1'b0;
        end
    end

    // Second status register; reserved positions read zero
    always_comb begin
        status2 = 8'h00;
        status2[smi_routing_pkg::BIT_MOUSE]       = mouse_level;
        status2[smi_routing_pkg::BIT_KEYBOARD]    = keyboard_level;
        status2[smi_routing_pkg::BIT_INFRARED]    = infrared_seen;
        status2[smi_routing_pkg::BIT_MOUSE_CLICK] = click_seen;
    end

    // Second enable; reserved bit 3 is not stored, so it reads zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            en2 <= smi_routing_pkg::REG_RESET;
        end else if (wr && (addr == smi_routing_pkg::OFF_EN2)) begin
            en2 <= wdata & smi_routing_pkg::EN2_WRITE_MASK;
        end
    end

    // Third enable: GPIO gates, bit 0 unused
    always_ff @(posedge mclk) begin
        if (rst) begin
            en3 <= smi_routing_pkg::REG_RESET;
        end else if (wr && (addr == smi_routing_pkg::OFF_EN3)) begin
            en3 <= wdata & smi_routing_pkg::EN3_MASK;
        end
    end

    // Fourth enable; the two-port build cannot set its UART gates
    always_ff @(posedge mclk) begin
        if (rst) begin
            en4 <= smi_routing_pkg::REG_RESET;
        end else if (wr && (addr == smi_routing_pkg::OFF_EN4)) begin
            en4 <= wdata & en4_mask;
        end
    end

    // Local interrupt enable register
    // Only the two event positions are stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            evt_enable <= smi_routing_pkg::REG_RESET;
        end else if (wr && (addr == smi_routing_pkg::OFF_EVT_ENABLE)) begin
            evt_enable <= wdata & smi_routing_pkg::EVT_MASK;
        end
    end

    // Group term: any source with status and enable both set
    // Misc edges stay out of it; they feed only the local interrupt
    assign next_group = |(status2 & en2 & smi_routing_pkg::EN2_SOURCE_MASK)
                      | |(status3 & en3)
                      | |(status4 & en4);

    // Local events: group rising, or a misc edge latched
    always_comb begin
        evt_set = 8'h00;
        evt_set[smi_routing_pkg::EVT_GROUP] = next_group && !group_mgmt_irq;
        evt_set[smi_routing_pkg::EVT_MISC]  = |(set_misc & smi_routing_pkg::MISC_MASK);
    end

    // Group level, one edge after status and enable meet
    always_ff @(posedge mclk) begin
        if (rst) begin
            group_mgmt_irq <= 1'b0;
        end else begin
            group_mgmt_irq <= next_group;
        end
    end

    // Pin route; active low and push-pull, so it idles high
    // Registered beside the group flop, so pin and group move together
    always_ff @(posedge mclk) begin
        if (rst) begin
            mgmt_irq_out_pin_n <= 1'b1;
        end else begin
            mgmt_irq_out_pin_n <= !(next_group && en2[smi_routing_pkg::BIT_TO_PIN]);
        end
    end

    // Serial stream route
    always_ff @(posedge mclk) begin
        if (rst) begin
            serial_irq_request <= 1'b0;
        end else begin
            serial_irq_request <= next_group && en2[smi_routing_pkg::BIT_TO_SERIAL];
        end
    end

    // Wake-event route
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_event_request <= 1'b0;
        end else begin
            wake_event_request <= next_group && en2[smi_routing_pkg::BIT_TO_WAKE];
        end
    end

    // Level interrupt; one cycle behind the status it follows
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status & evt_enable);
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    // Status three, four and misc reads are masked so unstored positions never leak
    always_comb begin
        next_rdata = 8'h00;
        case (addr)
            smi_routing_pkg::OFF_STATUS2:    next_rdata = status2;
            smi_routing_pkg::OFF_STATUS3:    next_rdata = status3 & smi_routing_pkg::EN3_MASK;
            smi_routing_pkg::OFF_STATUS4:    next_rdata = status4 & en4_mask;
            smi_routing_pkg::OFF_EN2:        next_rdata = en2;
            smi_routing_pkg::OFF_EN3:        next_rdata = en3;
            smi_routing_pkg::OFF_EN4:        next_rdata = en4;
            smi_routing_pkg::OFF_MISC:       next_rdata = misc_status
                                                        & smi_routing_pkg::MISC_MASK;
            smi_routing_pkg::OFF_EVT_STATUS: next_rdata = evt_status;
            smi_routing_pkg::OFF_EVT_ENABLE: next_rdata = evt_enable;
            default:                         next_rdata = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    // Zero outside that cycle, so a stale answer is never taken
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule

// ===== hw/smi_routing_pkg.sv
package smi_routing_pkg;

    // Register offsets on the plain register port
    localparam logic [7:0] OFF_STATUS2    = 8'h15;
    localparam logic [7:0] OFF_STATUS3    = 8'h16;
    localparam logic [7:0] OFF_STATUS4    = 8'h17;
    localparam logic [7:0] OFF_EN2        = 8'h19;
    localparam logic [7:0] OFF_EN3        = 8'h1a;
    localparam logic [7:0] OFF_EN4        = 8'h1b;
    localparam logic [7:0] OFF_MISC       = 8'h1c;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h20;
    localparam logic [7:0] OFF_EVT_CLEAR  = 8'h21;
    localparam logic [7:0] OFF_EVT_ENABLE = 8'h22;

    // Reset value of every register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Second enable register and second status register fields
    localparam int BIT_MOUSE       = 0;
    localparam int BIT_KEYBOARD    = 1;
    localparam int BIT_INFRARED    = 2;
    localparam int BIT_MOUSE_CLICK = 4;
    localparam int BIT_TO_WAKE     = 5;
    localparam int BIT_TO_SERIAL   = 6;
    localparam int BIT_TO_PIN      = 7;

    // Writable and implemented bits per register
    localparam logic [7:0] EN2_SOURCE_MASK = 8'h17;
    localparam logic [7:0] EN2_WRITE_MASK  = 8'hf7;
    localparam logic [7:0] EN3_MASK        = 8'hfe;
    localparam logic [7:0] EN4_SIX_MASK    = 8'hff;
    localparam logic [7:0] EN4_TWO_MASK    = 8'hac;
    localparam logic [7:0] MISC_MASK       = 8'h33;

    // Synchronised pin indices
    localparam int NUM_PINS = 12;
    localparam int PIN_GPIO_LINE_21 = 0;
    localparam int PIN_GPIO_LINE_22 = 1;
    localparam int PIN_GPIO_LINE_54 = 2;
    localparam int PIN_GPIO_LINE_55 = 3;
    localparam int PIN_GPIO_LINE_56 = 4;
    localparam int PIN_GPIO_LINE_57 = 5;
    localparam int PIN_GPIO_LINE_60 = 6;
    localparam int PIN_GPIO_LINE_61 = 7;
    localparam int PIN_GPIO_LINE_32 = 8;
    localparam int PIN_GPIO_LINE_33 = 9;
    localparam int PIN_GPIO_LINE_42 = 10;
    localparam int PIN_IR   = 11;

    // Block event bits for the local interrupt
    localparam int EVT_GROUP = 0;
    localparam int EVT_MISC  = 1;
    localparam logic [7:0] EVT_MASK = 8'h03;

endpackage
